// ### src/idin_top.sv
// Isolated sixteen-channel digital input card with interrupt byte and gate/flag handshake.
`timescale 1ns/100ps

// Overview of operation
// - Sixteen isolated channels sampled for input.
// - Only channels zero to seven interrupt.
// - High channels read while low ones interrupt.
// - Programmed edge sets input byte bit.
// - Interrupt bit needs mask and input bit.
// - Any interrupt bit raises mainframe status.
// - Status forwarded only when request mask set.
// - Enable command loads eight-bit channel mask.
// - Sense command picks rising or falling edges.
// - Continuous read repeatedly returns input word.
// - Single read gives one reading per command.
// - Reads report input, not interrupt byte.
// - Handshake off by default, strap enables on a control write.
// - Read command drives gate to ready.
// - Flag edge returns gate busy, captures word.
// - Flag rising by default, strap selects falling on a control write.
// - Readings paced at four hundred per second.
// - View command dedicates display, empty cancels.
// - Read values span zero to all ones.
module idin_top #(
    parameter int NCHAN = 16,
    parameter int NIRQ = 8,
    parameter int PACE_CYCLES = idin_pkg::idin_read_period_cycles
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Isolated inputs and handshake
    input wire logic [NCHAN-1:0] chan_in,
    input wire logic flag_in,
    input wire logic hs_strap,
    input wire logic flag_fall_strap,
    output logic gate_ready,
    // Mainframe side
    output logic status_digital_irq,
    output logic srq_out,
    output logic [NCHAN-1:0] read_word,
    output logic read_strobe
);
    initial begin
        if (NCHAN != 16 || NIRQ != 8) begin
            $error("Card serves sixteen channels with eight interrupt channels");
        end
    end

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hs_en;
        logic flag_fall;
        logic [NIRQ-1:0] irq_mask;
        logic [NIRQ-1:0] sense;
        logic [NIRQ-1:0] input_byte;
        logic [NIRQ-1:0] irq_byte;
        logic [NCHAN-1:0] word;
        logic word_valid;
        logic cont;
        logic single_pend;
        idin_pkg::idin_rd_e rd;
        logic gate_ready;
        logic status_bit;
        logic srq_mask;
        logic srq;
        logic read_strobe;
        logic [8:0] view;
    } idin_s;
    idin_s st;
    idin_s next_st;

    logic [NCHAN:0] lvl;
    logic [NCHAN:0] rise;
    logic [NCHAN:0] fall;
    logic pace_tick;
    logic [NIRQ-1:0] edge_hit;
    logic flag_edge;
    logic rd_req;

    // ==========================================================
    // Input conditioning
    idin_sync #(.WIDTH(NCHAN + 1)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .raw({flag_in, chan_in}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    idin_pace #(.PERIOD(PACE_CYCLES)) u_pace (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(pace_tick)
    );

    function automatic logic [31:0] idin_rd_mux(input idin_s s, input logic [7:0] a);
        logic [31:0] d;
        d = '0;
        case (a)
            idin_pkg::idin_off_ctrl: begin
                d[idin_pkg::idin_ctrl_hs_en] = s.hs_en;
                d[idin_pkg::idin_ctrl_flag_fall] = s.flag_fall;
            end
            idin_pkg::idin_off_irq_mask: d[NIRQ-1:0] = s.irq_mask;
            idin_pkg::idin_off_sense: d[NIRQ-1:0] = s.sense;
            idin_pkg::idin_off_irq_status: d[NIRQ-1:0] = s.irq_byte;
            idin_pkg::idin_off_input_byte: d[NIRQ-1:0] = s.input_byte;
            idin_pkg::idin_off_read_word: d[NCHAN-1:0] = s.word;
            idin_pkg::idin_off_status: begin
                d[idin_pkg::idin_st_gate_ready] = s.gate_ready;
                d[idin_pkg::idin_st_word_valid] = s.word_valid;
                d[idin_pkg::idin_st_reading] = s.cont;
                d[idin_pkg::idin_st_status_bit] = s.status_bit;
                d[idin_pkg::idin_st_irq_req] = s.srq;
            end
            idin_pkg::idin_off_view: d[8:0] = s.view;
            idin_pkg::idin_off_srq_mask: d[0] = s.srq_mask;
            default: d = '0;
        endcase
        return d;
    endfunction : idin_rd_mux

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.read_strobe = 1'b0;
        flag_edge = st.flag_fall ? fall[NCHAN] : rise[NCHAN];
        // Each bit picks its own edge polarity.
        edge_hit = (st.sense & rise[NIRQ-1:0]) | (~st.sense & fall[NIRQ-1:0]);
        rd_req = 1'b0;

        // Bus: reads answer in the data phase, writes land one cycle after address.
        if (hsel && hready && htrans[1]) begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = haddr[7:0];
            next_st.hrdata = hwrite ? 32'h0 : idin_rd_mux(st, haddr[7:0]);
        end else begin
            next_st.wr_pend = 1'b0;
        end

        if (st.wr_pend) begin
            case (st.wr_addr)
                idin_pkg::idin_off_ctrl: begin
                    next_st.hs_en = hwdata[idin_pkg::idin_ctrl_hs_en] | hs_strap;
                    next_st.flag_fall = hwdata[idin_pkg::idin_ctrl_flag_fall] | flag_fall_strap;
                end
                idin_pkg::idin_off_irq_mask: next_st.irq_mask = hwdata[NIRQ-1:0];
                idin_pkg::idin_off_sense: next_st.sense = hwdata[NIRQ-1:0];
                idin_pkg::idin_off_cmd: begin
                    if (hwdata[idin_pkg::idin_cmd_single]) begin
                        next_st.single_pend = 1'b1;
                        rd_req = 1'b1;
                    end
                    if (hwdata[idin_pkg::idin_cmd_cont]) begin
                        next_st.cont = 1'b1;
                        rd_req = 1'b1;
                    end
                    if (hwdata[idin_pkg::idin_cmd_stop]) begin
                        next_st.cont = 1'b0;
                    end
                end
                idin_pkg::idin_off_view: next_st.view = hwdata[8:0];
                idin_pkg::idin_off_srq_mask: next_st.srq_mask = hwdata[0];
                default: begin
                end
            endcase
        end

        // Input byte: edges set, a clear command clears, set wins.
        if (st.wr_pend && st.wr_addr == idin_pkg::idin_off_cmd
            && hwdata[idin_pkg::idin_cmd_clr_input]) begin
            next_st.input_byte = edge_hit;
        end else begin
            next_st.input_byte = st.input_byte | edge_hit;
        end
        next_st.irq_byte = next_st.input_byte & next_st.irq_mask;
        next_st.status_bit = |st.irq_byte;
        next_st.srq = st.status_bit & st.srq_mask;

        // Read sequencer.
        case (st.rd)
            idin_pkg::idin_idle: begin
                if (rd_req || (st.cont && pace_tick)) begin
                    if (st.hs_en) begin
                        next_st.gate_ready = 1'b1;
                        next_st.rd = idin_pkg::idin_wait_flag;
                    end else begin
                        // Without handshake software must time reads itself.
                        next_st.word = lvl[NCHAN-1:0];
                        next_st.rd = idin_pkg::idin_done;
                    end
                end
            end
            idin_pkg::idin_wait_flag: begin
                if (flag_edge) begin
                    next_st.gate_ready = 1'b0;
                    next_st.word = lvl[NCHAN-1:0];
                    next_st.rd = idin_pkg::idin_done;
                end
            end
            idin_pkg::idin_done: begin
                next_st.word_valid = 1'b1;
                next_st.read_strobe = 1'b1;
                next_st.single_pend = 1'b0;
                next_st.rd = idin_pkg::idin_idle;
            end
            default: next_st.rd = idin_pkg::idin_idle;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.irq_mask <= idin_pkg::idin_mask_reset;
            st.sense <= idin_pkg::idin_sense_reset;
            st.rd <= idin_pkg::idin_idle;
        end else begin
            st <= next_st;
        end
    end

    // Straps act only through a write to the control register, which ORs them in.
    assign hrdata = st.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign gate_ready = st.gate_ready;
    assign status_digital_irq = st.status_bit;
    assign srq_out = st.srq;
    assign read_word = st.word;
    assign read_strobe = st.read_strobe;
endmodule : idin_top

// ### src/idin_pkg.sv
// Package with register map, field layout and timing constants of the isolated input card.
package idin_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] idin_off_ctrl = 8'h00;
    localparam logic [7:0] idin_off_irq_mask = 8'h04;
    localparam logic [7:0] idin_off_sense = 8'h08;
    localparam logic [7:0] idin_off_irq_status = 8'h0c;
    localparam logic [7:0] idin_off_input_byte = 8'h10;
    localparam logic [7:0] idin_off_read_word = 8'h14;
    localparam logic [7:0] idin_off_cmd = 8'h18;
    localparam logic [7:0] idin_off_status = 8'h1c;
    localparam logic [7:0] idin_off_view = 8'h20;
    localparam logic [7:0] idin_off_srq_mask = 8'h24;
    // ==========================================================
    // Field positions
    localparam int idin_ctrl_hs_en = 0;
    localparam int idin_ctrl_flag_fall = 1;
    localparam int idin_cmd_single = 0;
    localparam int idin_cmd_cont = 1;
    localparam int idin_cmd_stop = 2;
    localparam int idin_cmd_clr_input = 3;
    localparam int idin_st_gate_ready = 0;
    localparam int idin_st_word_valid = 1;
    localparam int idin_st_reading = 2;
    localparam int idin_st_status_bit = 3;
    localparam int idin_st_irq_req = 4;
    localparam int idin_view_en = 8;
    // ==========================================================
    // Reset values and timing
    localparam logic [7:0] idin_mask_reset = 8'h00;
    localparam logic [7:0] idin_sense_reset = 8'h00;
    localparam int idin_clk_hz = 25_000_000;
    localparam int idin_read_rate_hz = 400;
    localparam int idin_read_period_cycles = idin_clk_hz / idin_read_rate_hz;
    typedef enum logic [2:0] {
        idin_idle = 3'b001,
        idin_wait_flag = 3'b010,
        idin_done = 3'b100
    } idin_rd_e;
endpackage : idin_pkg

// ### src/idin_sync.sv
// Two-stage synchroniser bank with edge detection on the stable stage.
`timescale 1ns/100ps
module idin_sync #(
    parameter int WIDTH = 17
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Raw and synchronised lines
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } idin_sync_s;
    idin_sync_s st;
    idin_sync_s next_st;

    // ==========================================================
    // Only s2 and s3 feed logic; s1 is read by s2 alone.
    always_comb begin
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.s2;
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
endmodule : idin_sync

// ### src/idin_pace.sv
// Pacing divider that limits continuous readings to the documented rate.
`timescale 1ns/100ps
module idin_pace #(
    parameter int PERIOD = idin_pkg::idin_read_period_cycles
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Tick output
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } idin_pace_s;
    idin_pace_s st;
    idin_pace_s next_st;

    initial begin
        if (PERIOD < 1) begin
            $error("PERIOD must be at least one");
        end
    end

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt >= 32'(PERIOD - 1)) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : idin_pace

// ### bench/idin_asserts.sv
// Port checker for the isolated input card.
`timescale 1ns/100ps
module idin_asserts #(
    parameter int NCHAN = 16
) (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Handshake and mainframe side
    input wire logic flag_in,
    input wire logic gate_ready,
    input wire logic status_digital_irq,
    input wire logic srq_out,
    input wire logic [NCHAN-1:0] read_word,
    input wire logic read_strobe
);
    // ==========================================================
    // Helper logic
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic tk;
    logic rd_irq;
    logic rd_wd;
    logic cmd_w;
    logic fl_q;
    logic [3:0] fc;
    assign tk = hsel && hready && htrans[1];
    always_ff @(posedge ref_clk) begin
        rd_irq <= tk && !hwrite && haddr[7:0] == idin_pkg::idin_off_irq_status;
        rd_wd <= tk && !hwrite && haddr[7:0] == idin_pkg::idin_off_read_word;
        cmd_w <= tk && hwrite && haddr[7:0] == idin_pkg::idin_off_cmd;
        fl_q <= flag_in;
        // Saturating age of the last flag change, so a late capture is still caught.
        fc <= (rst || flag_in != fl_q) ? 4'h0 : (fc == 4'hf ? fc : fc + 4'h1);
    end
    // ==========================================================
    // Assertions
    irq_width_a: assert property (rd_irq |-> hrdata[31:8] == 24'h0) else $error("irq wide");
    word_width_a: assert property (rd_wd |-> hrdata[31:16] == 16'h0) else $error("word wide");
    srq_gate_a: assert property (srq_out |-> $past(status_digital_irq)) else $error("srq");
    strobe_one_a: assert property (read_strobe |=> !read_strobe) else $error("strobe");
    gate_strobe_a: assert property ($fell(gate_ready) |=> read_strobe) else $error("no read");
    word_strobe_a: assert property ($changed(read_word) |=> read_strobe) else $error("word");
    gate_cmd_a:
        assert property ($rose(gate_ready) |-> $past(cmd_w) || $past(cmd_w, 2))
        else $error("Gate rose without a read command.");
    flag_gate_a:
        assert property ($fell(gate_ready) |-> fc >= 4'h1 && fc <= 4'h6)
        else $error("Gate dropped without a flag edge.");
    srq_c: cover property ($rose(srq_out));
    hs_c: cover property ($fell(gate_ready));
    irq_c: cover property (rd_irq && hrdata[7:0] != 8'h0);
endmodule : idin_asserts

bind idin_top idin_asserts #(.NCHAN(NCHAN)) u_idin_asserts (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .flag_in(flag_in),
    .gate_ready(gate_ready), .status_digital_irq(status_digital_irq),
    .srq_out(srq_out), .read_word(read_word), .read_strobe(read_strobe)
);

// ### bench/idin_source.sv
// Behavioural data source answering the gate with a word and a flag edge.
`timescale 1ns/100ps
module idin_source (
    // Handshake
    input wire logic ref_clk,
    input wire logic gate_ready,
    output logic flag,
    // Stimulus
    input wire logic fall_mode,
    input wire logic [7:0] dly,
    input wire logic [15:0] word,
    output logic [15:0] data,
    output logic busy
);
    logic act = 1'b0;
    logic [7:0] cnt = 8'h0;
    // Idle level opposes the sensed edge, so only a real answer is an edge.
    assign flag = fall_mode ^ act;
    initial begin
        busy = 1'b0;
        data = 16'h0;
    end
    always @(posedge ref_clk) begin
        if (gate_ready && !busy) begin
            busy <= 1'b1;
            cnt <= dly;
            data <= word;
        end else if (busy && cnt != 8'h0) begin
            cnt <= cnt - 8'h1;
        end else if (busy && !act) begin
            act <= 1'b1;
        end else if (busy && !gate_ready) begin
            busy <= 1'b0;
            act <= 1'b0;
            data <= ~word;
        end
    end
endmodule : idin_source

// ### bench/tb_top.sv
// Self-checking bench for the isolated input card.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    $display("Error %s expected %h seen %h", nm, ex, gt); failures++; end end
module tb_top;
    typedef struct packed {
        logic [15:0] b;
        logic [15:0] a;
        logic [7:0] m;
        logic [7:0] s;
        logic q;
    } idin_row_s;
    localparam int PACE = 16;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] tb_chan = 16'h0;
    logic hs_strap = 1'b0;
    logic fall_mode = 1'b0;
    logic [7:0] dly = 8'h0;
    logic [15:0] word = 16'h0;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic [15:0] chan_in;
    logic [15:0] src_data;
    logic [15:0] read_word;
    logic hready;
    logic src_busy;
    logic flag_in;
    logic gate_ready;
    logic status_digital_irq;
    logic srq_out;
    logic read_strobe;
    int failures = 0;
    int n_checks = 0;
    int strobes = 0;
    assign chan_in = src_busy ? src_data : tb_chan;
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (read_strobe === 1'b1) strobes++;
    idin_top #(.PACE_CYCLES(PACE)) u_idin_top (
        .ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .chan_in(chan_in), .flag_in(flag_in),
        .hs_strap(hs_strap), .flag_fall_strap(fall_mode), .gate_ready(gate_ready),
        .status_digital_irq(status_digital_irq), .srq_out(srq_out),
        .read_word(read_word), .read_strobe(read_strobe)
    );
    idin_source u_idin_source (
        .ref_clk(ref_clk), .gate_ready(gate_ready), .flag(flag_in), .fall_mode(fall_mode),
        .dly(dly), .word(word), .data(src_data), .busy(src_busy)
    );
    task automatic close_out();
        $display("Checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // Waits for a strobe or the bus ready, and gives up after lim edges.
    task automatic wait_on(input bit strb, input int lim);
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while ((strb ? read_strobe : hready) !== 1'b1 && k < lim);
        if (k >= lim) begin
            failures++;
            close_out();
        end
    endtask : wait_on
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_on(0, 50);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_on(0, 50);
        rd = hrdata;
    endtask : bus
    initial begin
        idin_row_s rows [6];
        logic [7:0] e;
        rows = '{'{16'h0000, 16'h0001, 8'h01, 8'h01, 1'b1}, '{16'hffff, 16'h0, 8'h0, 8'h0, 1'b1},
            '{16'h0, 16'hff00, 8'hff, 8'hff, 1'b1}, '{16'h0081, 16'h0, 8'h01, 8'h0, 1'b0},
            '{16'h0, 16'h00ff, 8'h24, 8'h24, 1'b1}, '{16'h00ff, 16'h0, 8'hff, 8'h24, 1'b1}};
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            tb_chan <= rows[i].b;
            bus(1, idin_pkg::idin_off_irq_mask, {24'h0, rows[i].m});
            bus(1, idin_pkg::idin_off_sense, {24'h0, rows[i].s});
            bus(1, idin_pkg::idin_off_srq_mask, {31'h0, rows[i].q});
            repeat (6) @(posedge ref_clk);
            bus(1, idin_pkg::idin_off_cmd, 32'h8);
            tb_chan <= rows[i].a;
            repeat (8) @(posedge ref_clk);
            e = (~rows[i].b[7:0] & rows[i].a[7:0] & rows[i].s);
            e = e | (rows[i].b[7:0] & ~rows[i].a[7:0] & ~rows[i].s);
            bus(0, idin_pkg::idin_off_input_byte, 32'h0);
            `CHK("input byte", {24'h0, e}, rd)
            bus(0, idin_pkg::idin_off_irq_status, 32'h0);
            `CHK("irq byte", {24'h0, e & rows[i].m}, rd)
            `CHK("status bit", |(e & rows[i].m), status_digital_irq)
            `CHK("srq", |(e & rows[i].m) & rows[i].q, srq_out)
            bus(1, idin_pkg::idin_off_cmd, 32'h1);
            wait_on(1, 20);
            `CHK("read word", rows[i].a, read_word)
            bus(0, idin_pkg::idin_off_read_word, 32'h0);
            `CHK("word reg", {16'h0, rows[i].a}, rd)
        end
        for (int m = 0; m < 2; m++) begin
            hs_strap <= m[0];
            fall_mode <= m[0];
            dly <= m[0] ? 8'hc : 8'h3;
            word <= m[0] ? 16'h5a3c : 16'ha5c3;
            // In the strapped pass the straps force both control bits even though zero is written; the other pass writes hs_en.
            bus(1, idin_pkg::idin_off_ctrl, {31'h0, !m[0]});
            repeat (4) @(posedge ref_clk);
            strobes = 0;
            bus(1, idin_pkg::idin_off_cmd, 32'h1);
            wait_on(1, 60);
            `CHK("hs word", word, read_word)
            `CHK("gate busy", 1'b0, gate_ready)
            repeat (40) @(posedge ref_clk);
            `CHK("one reading", 1, strobes)
        end
        hs_strap <= 1'b0;
        fall_mode <= 1'b0;
        tb_chan <= 16'hffff;
        bus(1, idin_pkg::idin_off_ctrl, 32'h0);
        bus(1, idin_pkg::idin_off_cmd, 32'h2);
        wait_on(1, 10);
        @(posedge ref_clk);
        wait_on(1, 40);
        @(posedge ref_clk);
        strobes = 0;
        repeat (PACE * 4 + PACE / 2) @(posedge ref_clk);
        `CHK("paced readings", 4, strobes)
        `CHK("paced word", 16'hffff, read_word)
        bus(1, idin_pkg::idin_off_cmd, 32'h4);
        repeat (2) @(posedge ref_clk);
        strobes = 0;
        repeat (PACE * 3) @(posedge ref_clk);
        `CHK("stopped", 0, strobes)
        bus(1, idin_pkg::idin_off_view, 32'h105);
        bus(1, 8'h3c, 32'hffff);
        bus(0, idin_pkg::idin_off_view, 32'h0);
        `CHK("view", 32'h105, rd)
        bus(0, 8'h3c, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        `CHK("status after reset", 1'b0, status_digital_irq)
        bus(0, idin_pkg::idin_off_irq_mask, 32'h0);
        `CHK("mask after reset", 32'h0, rd)
        bus(0, idin_pkg::idin_off_ctrl, 32'h0);
        `CHK("ctrl after reset", 32'h0, rd)
        close_out();
    end
endmodule : tb_top
